// >>> rtl/pwmcs_channel.sv
// pwm channel control slot: axi4-lite registers, setpoint and slot handling, output select
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pwmcs_channel #(
	parameter int MODULE_CYCLE_CYC = pwmcs_pkg::MODULE_CYCLE_CYC_DEF,
	parameter logic [31:0] PERIOD_CFG_US = pwmcs_pkg::PERIOD_CFG_US_DEF
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register bus
	input wire pwmcs_pkg::pwmcs_axi_req_t axi_req,
	output pwmcs_pkg::pwmcs_axi_rsp_t axi_rsp,
	// pulse output and status
	output logic pulse_output_a,
	output logic sequence_active_status
);
	import pwmcs_pkg::*;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction

	function automatic logic period_ok(input logic [31:0] p, input logic hs);
		return (p >= (hs ? PERIOD_MIN_HS_US : PERIOD_MIN_STD_US)) && (p <= PERIOD_MAX_US);
	endfunction

	//==============================================================
	// axi4-lite write path
	logic aw_held_q, w_held_q, bvalid_q, wr_fire, wr_mapped;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	logic awready, wready;

	assign awready = !aw_held_q && !bvalid_q;
	assign wready = !w_held_q && !bvalid_q;
	assign wr_fire = aw_held_q && w_held_q;
	assign wr_mapped = (awaddr_q == ADR_SETPOINT) || (awaddr_q == ADR_SLOT_VALUE)
		|| (awaddr_q == ADR_SLOT_CTRL) || (awaddr_q == ADR_CONTROL);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= RST_WORD;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (axi_req.awvalid && awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q <= axi_req.awaddr;
			end
			if (axi_req.wvalid && wready)
			begin
				w_held_q <= 1'b1;
				wdata_q <= axi_req.wdata;
				wstrb_q <= axi_req.wstrb;
			end
			if (wr_fire)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && axi_req.bready)
				bvalid_q <= 1'b0;
		end
	end

	//==============================================================
	// software registers
	logic [31:0] setpoint_q, slot_value_q, slot_ctrl_q, control_q;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			setpoint_q <= RST_WORD;
			slot_value_q <= RST_WORD;
			slot_ctrl_q <= RST_WORD;
			control_q <= RST_WORD;
		end
		else if (wr_fire)
		begin
			if (awaddr_q == ADR_SETPOINT)
				setpoint_q <= merge_bytes(setpoint_q, wdata_q, wstrb_q);
			if (awaddr_q == ADR_SLOT_VALUE)
				slot_value_q <= merge_bytes(slot_value_q, wdata_q, wstrb_q);
			if (awaddr_q == ADR_SLOT_CTRL)
				slot_ctrl_q <= merge_bytes(slot_ctrl_q, wdata_q, wstrb_q) & SLOT_CTRL_MASK;
			if (awaddr_q == ADR_CONTROL)
				control_q <= merge_bytes(control_q, wdata_q, wstrb_q) & CONTROL_MASK;
		end
	end

	logic software_run_enable, channel_owns_output, direct_output_level, error_clear_request;
	logic freq_mode, run_mode, high_speed, slot_cyclic;
	logic [3:0] aux_param_selector;

	assign software_run_enable = control_q[CT_ENABLE];
	assign channel_owns_output = control_q[CT_OWNS];
	assign direct_output_level = control_q[CT_LEVEL];
	assign error_clear_request = control_q[CT_ERR_CLR];
	assign freq_mode = control_q[CT_FREQ];
	assign run_mode = control_q[CT_RUN];
	assign high_speed = control_q[CT_HSPEED];
	assign aux_param_selector = slot_ctrl_q[SC_SEL_LSB +: 4];
	assign slot_cyclic = slot_ctrl_q[SC_MODE_BIT];

	//==============================================================
	// run edge, enable edge and module cycle
	logic run_prev_q, en_prev_q, active_q, stop_run, cyc_tick;
	logic [$clog2(MODULE_CYCLE_CYC+1)-1:0] cyc_cnt_q;

	assign stop_run = run_mode && !run_prev_q;
	assign cyc_tick = (cyc_cnt_q == $bits(cyc_cnt_q)'(MODULE_CYCLE_CYC - 1));

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			run_prev_q <= 1'b0;
			en_prev_q <= 1'b0;
		end
		else
		begin
			run_prev_q <= run_mode;
			en_prev_q <= software_run_enable;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || cyc_tick)
			cyc_cnt_q <= '0;
		else
			cyc_cnt_q <= cyc_cnt_q + 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || stop_run || !run_mode || !software_run_enable)
			active_q <= 1'b0;
		else if (software_run_enable && !en_prev_q)
			active_q <= 1'b1;
	end

	//==============================================================
	// setpoint check
	logic setpoint_range_error_q, have_valid_q;
	logic [31:0] freq_q;
	logic [15:0] duty_q;
	logic freq_ok;

	assign freq_ok = (setpoint_q >= FREQ_MIN_HZ) && (setpoint_q <= FREQ_MAX_HZ);

	always_ff @(posedge clk_sys)
	begin
		if (rst || stop_run)
		begin
			setpoint_range_error_q <= 1'b0;
			have_valid_q <= 1'b0;
			freq_q <= RST_WORD;
		end
		else if (freq_mode)
		begin
			if (freq_ok)
			begin
				freq_q <= setpoint_q;
				have_valid_q <= 1'b1;
				setpoint_range_error_q <= 1'b0;
			end
			else
				setpoint_range_error_q <= 1'b1;
		end
		else
			setpoint_range_error_q <= 1'b0;
	end

	// duty in the two low bytes, signed; clamp rather than flag
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			duty_q <= 16'h0000;
		else if (setpoint_q[15])
			duty_q <= 16'h0000;
		else if (setpoint_q[15:0] > DUTY_FULL)
			duty_q <= DUTY_FULL;
		else
			duty_q <= setpoint_q[15:0];
	end

	//==============================================================
	// slot handling, evaluated once per module cycle
	logic [3:0] last_sel_q;
	logic aux_load_ack_toggle_q, load_error_flag_q, aux_value_error_q;
	logic [31:0] period_q, record_q;
	logic sel_valid, val_ok, ld_err_set;

	assign sel_valid = (aux_param_selector == SEL_NONE)
		|| (aux_param_selector == SEL_PERIOD && !freq_mode);
	assign val_ok = period_ok(slot_value_q, high_speed);
	assign ld_err_set = cyc_tick && !slot_cyclic && !load_error_flag_q
		&& (aux_param_selector != last_sel_q) && !(sel_valid && (aux_param_selector == SEL_NONE || val_ok));

	always_ff @(posedge clk_sys)
	begin
		if (rst || stop_run)
		begin
			last_sel_q <= SEL_NONE;
			aux_load_ack_toggle_q <= 1'b0;
			aux_value_error_q <= 1'b0;
			period_q <= PERIOD_CFG_US;
			record_q <= PERIOD_CFG_US;
		end
		else if (cyc_tick)
		begin
			if (!slot_cyclic)
			begin
				aux_value_error_q <= 1'b0;
				// a pending error blocks new loads until cleared and presented again
				if (aux_param_selector != last_sel_q && !load_error_flag_q)
				begin
					last_sel_q <= aux_param_selector;
					if (aux_param_selector == SEL_NONE)
						aux_load_ack_toggle_q <= !aux_load_ack_toggle_q;
					else if (sel_valid && val_ok)
					begin
						period_q <= slot_value_q;
						record_q <= slot_value_q;
						aux_load_ack_toggle_q <= !aux_load_ack_toggle_q;
					end
				end
			end
			else if (aux_param_selector == SEL_PERIOD && !freq_mode)
			begin
				last_sel_q <= aux_param_selector;
				if (val_ok)
				begin
					period_q <= slot_value_q;
					aux_value_error_q <= 1'b0;
				end
				else
					aux_value_error_q <= 1'b1;
			end
			else
				last_sel_q <= aux_param_selector;
		end
	end

	// sticky: a new error in the same cycle as a clear request wins
	always_ff @(posedge clk_sys)
	begin
		if (rst || stop_run)
			load_error_flag_q <= 1'b0;
		else if (ld_err_set)
			load_error_flag_q <= 1'b1;
		else if (error_clear_request)
			load_error_flag_q <= 1'b0;
	end

	//==============================================================
	// generator and output select
	logic wave, pulse_q;

	// generator runs while the sequence is active, whoever owns the pin
	pwmcs_pulse_gen u_gen (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(active_q),
		.freq_mode(freq_mode),
		.period_us(period_q),
		.duty(duty_q),
		.freq_hz(freq_q),
		.wave(wave)
	);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pulse_q <= 1'b0;
		else if (!channel_owns_output)
			pulse_q <= direct_output_level;
		else if (!active_q || (freq_mode && !have_valid_q))
			pulse_q <= 1'b0;
		else
			pulse_q <= wave;
	end

	assign pulse_output_a = pulse_q;
	assign sequence_active_status = active_q;

	//==============================================================
	// axi4-lite read path
	logic rvalid_q;
	logic [31:0] rdata_q, rd_word, feedback;
	logic [1:0] rresp_q;
	logic rd_ok;

	always_comb
	begin
		feedback = RST_WORD;
		feedback[FB_VAL_ERR] = aux_value_error_q;
		feedback[FB_SET_ERR] = setpoint_range_error_q;
		feedback[FB_LD_ERR] = load_error_flag_q;
		feedback[FB_SW_EN] = software_run_enable;
		feedback[FB_ACK] = aux_load_ack_toggle_q;
		feedback[FB_DQA] = pulse_q;
		feedback[FB_ACTIVE] = active_q;
	end

	always_comb
	begin
		rd_ok = 1'b1;
		unique case (axi_req.araddr)
			ADR_SETPOINT: rd_word = setpoint_q;
			ADR_SLOT_VALUE: rd_word = slot_value_q;
			ADR_SLOT_CTRL: rd_word = slot_ctrl_q;
			ADR_CONTROL: rd_word = control_q;
			ADR_FEEDBACK: rd_word = feedback;
			ADR_RECORD: rd_word = record_q;
			ADR_PERIOD: rd_word = period_q;
			default:
			begin
				rd_word = RST_WORD;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= RST_WORD;
			rresp_q <= RESP_OKAY;
		end
		else if (axi_req.arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_q && axi_req.rready)
			rvalid_q <= 1'b0;
	end

	always_comb
	begin
		axi_rsp.awready = awready;
		axi_rsp.wready = wready;
		axi_rsp.bvalid = bvalid_q;
		axi_rsp.bresp = bresp_q;
		axi_rsp.arready = !rvalid_q;
		axi_rsp.rvalid = rvalid_q;
		axi_rsp.rdata = rdata_q;
		axi_rsp.rresp = rresp_q;
	end
endmodule // pwmcs_channel

// >>> include/pwmcs_pkg.sv
// package: constants, register map and bus carriers of the pwm channel control slot
//==============================================================
// Notes on behaviour
// - setpoint range error sets while output value is out of range, clears once valid.
// - during setpoint error the invalid value is ignored; last valid value drives pulses.
// - frequency mode with no valid value accepted yet holds the output at 0.
// - pwm duty never errors; above full scale gives 100 percent, negative gives 0.
// - a 0 to 1 edge of the software enable starts the output sequence.
// - owner bit 1 drives the generated sequence out, 0 drives the direct level.
// - under direct control output A is high for level 1 and low for 0.
// - the error clear request clears the sticky load error flag.
// - slot mode 0 applies the slot value only when the selector changes.
// - each accepted selector change in mode 0, back to 0 too, flips the ack toggle.
// - invalid selector in mode 0 sets load error; program clears it and re-presents.
// - mode 0 changes show in the readback record and are lost at restart.
// - slot mode 1 takes and checks the slot value every module cycle.
// - in slot mode 1 the ack toggle does not change.
// - mode 1 bad slot value sets value error, keeps last value, clears on valid.
// - mode 1 leaves the record alone; last value under old selector stays valid.
// - selector 0 with mode 0 stops cyclic update; parameters held until next change.
// - selector 0 is no action; 1 is an unsigned 32-bit period, pwm only.
// - period accepted up to 10 000 000 us, minimum 10 or 100 us by speed.
// - under direct control a running sequence keeps advancing internally.
// - owner bit 1 with no active sequence drives the output to 0.
package pwmcs_pkg;
	//==============================================================
	// clock and timing
	localparam int CLK_HZ = 20000000;
	localparam int CLK_PER_US = CLK_HZ / 1000000;
	localparam int MODULE_CYCLE_US = 500;
	localparam int MODULE_CYCLE_CYC_DEF = MODULE_CYCLE_US * CLK_PER_US;
	localparam logic [63:0] PHASE_K = 64'h1_0000_0000 / 64'(CLK_HZ);
	localparam logic [31:0] PERIOD_MIN_HS_US = 32'd10;
	localparam logic [31:0] PERIOD_MIN_STD_US = 32'd100;
	localparam logic [31:0] PERIOD_MAX_US = 32'd10000000;
	localparam logic [31:0] PERIOD_CFG_US_DEF = 32'd1000;
	localparam logic [15:0] DUTY_FULL = 16'h4000;
	localparam int DUTY_SHIFT = 14;
	localparam logic [31:0] FREQ_MIN_HZ = 32'd1;
	localparam logic [31:0] FREQ_MAX_HZ = 32'd100000;
	//==============================================================
	// register byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADR_SETPOINT = 8'h00;
	localparam logic [7:0] ADR_SLOT_VALUE = 8'h04;
	localparam logic [7:0] ADR_SLOT_CTRL = 8'h08;
	localparam logic [7:0] ADR_CONTROL = 8'h0C;
	localparam logic [7:0] ADR_FEEDBACK = 8'h10;
	localparam logic [7:0] ADR_RECORD = 8'h14;
	localparam logic [7:0] ADR_PERIOD = 8'h18;
	//==============================================================
	// fields
	localparam int SC_SEL_LSB = 0;
	localparam int SC_MODE_BIT = 4;
	localparam logic [31:0] SLOT_CTRL_MASK = 32'h0000_001F;
	localparam int CT_ENABLE = 0;
	localparam int CT_OWNS = 1;
	localparam int CT_LEVEL = 3;
	localparam int CT_ERR_CLR = 9;
	localparam int CT_FREQ = 16;
	localparam int CT_RUN = 17;
	localparam int CT_HSPEED = 18;
	localparam logic [31:0] CONTROL_MASK = 32'h0007_020B;
	localparam int FB_VAL_ERR = 7;
	localparam int FB_SET_ERR = 6;
	localparam int FB_LD_ERR = 2;
	localparam int FB_SW_EN = 13;
	localparam int FB_ACK = 10;
	localparam int FB_DQA = 17;
	localparam int FB_ACTIVE = 16;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_PERIOD = 4'h1;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	//==============================================================
	// axi4-lite carriers
	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} pwmcs_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pwmcs_axi_rsp_t;
endpackage

// >>> rtl/pwmcs_pulse_gen.sv
// pulse generator core: pwm from period and duty, or frequency from a phase accumulator
`timescale 1ns/1ps
module pwmcs_pulse_gen
	import pwmcs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// settings
	input wire logic run,
	input wire logic freq_mode,
	input wire logic [31:0] period_us,
	input wire logic [15:0] duty,
	input wire logic [31:0] freq_hz,
	// waveform
	output logic wave
);
	logic [4:0] us_div_q;
	logic [31:0] us_cnt_q;
	logic [31:0] high_us_q;
	logic [31:0] phase_q;
	logic us_tick;
	logic [47:0] high_prod;

	assign us_tick = (us_div_q == 5'(CLK_PER_US - 1));
	assign high_prod = period_us * duty;

	//==============================================================
	// microsecond base and pwm period counter
	always_ff @(posedge clk_sys)
	begin
		if (rst || !run)
		begin
			us_div_q <= 5'h00;
			us_cnt_q <= 32'h0000_0000;
			high_us_q <= 32'h0000_0000;
		end
		else
		begin
			us_div_q <= us_tick ? 5'h00 : us_div_q + 5'h01;
			if (us_tick)
			begin
				// the high time is latched only at a period boundary, but a new period_us applies to the running period at once
				if (us_cnt_q >= period_us || us_cnt_q == 32'h0)
				begin
					us_cnt_q <= 32'h0000_0001;
					high_us_q <= high_prod[DUTY_SHIFT +: 32];
				end
				else
					us_cnt_q <= us_cnt_q + 32'h1;
			end
		end
	end

	//==============================================================
	// frequency output, increment is an approximation of f * 2^32 / clk
	always_ff @(posedge clk_sys)
	begin
		if (rst || !run)
			phase_q <= 32'h0000_0000;
		else
			phase_q <= phase_q + 32'(64'(freq_hz) * PHASE_K);
	end

	assign wave = freq_mode ? phase_q[31] : (us_cnt_q != 32'h0 && us_cnt_q <= high_us_q);
endmodule // pwmcs_pulse_gen

// >>> tb/pwmcs_channel_properties.sv
// checker: bus timing and output control relations seen at the channel ports
`timescale 1ns/1ps
module pwmcs_channel_props
	import pwmcs_pkg::*;
#(
	parameter int MODULE_CYCLE_CYC = 1,
	parameter logic [31:0] PERIOD_CFG_US = 32'h0
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus and outputs
	input wire pwmcs_pkg::pwmcs_axi_req_t axi_req,
	input wire pwmcs_pkg::pwmcs_axi_rsp_t axi_rsp,
	input wire logic pulse_output_a,
	input wire logic sequence_active_status
);
	//==============================================================
	// shadow of the control word, one cycle ahead of the design's copy
	logic [31:0] ctl_q;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ctl_q <= 32'h0;
		else if (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && axi_req.awaddr == ADR_CONTROL)
			ctl_q <= axi_req.wdata & CONTROL_MASK;
	end
	//==============================================================
	// properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_wtake;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence s_rtake;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	property p_bans; s_wtake |=> ##1 axi_rsp.bvalid; endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_rans; s_rtake |=> axi_rsp.rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_bhold; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rd_unmapped; s_rtake ##0 (axi_req.araddr > ADR_PERIOD) |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0; endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
	property p_wr_ro; s_wtake ##0 (axi_req.awaddr >= ADR_FEEDBACK) |=> ##1 axi_rsp.bresp == RESP_SLVERR; endproperty
	a_wr_ro: assert property (p_wr_ro) else $error("read-only write not refused");
	property p_direct; !$past(ctl_q[CT_OWNS], 2) |-> pulse_output_a == $past(ctl_q[CT_LEVEL], 2); endproperty
	a_direct: assert property (p_direct) else $error("direct level not on output");
	property p_idle; $past(ctl_q[CT_OWNS], 2) && !$past(sequence_active_status) && !sequence_active_status |-> !pulse_output_a; endproperty
	a_idle: assert property (p_idle) else $error("output high with no sequence");
	// a write that raises run as well is a stop-run reset, not a start
	property p_start; $rose(ctl_q[CT_ENABLE]) && ctl_q[CT_RUN] && $past(ctl_q[CT_RUN]) |-> ##[1:4] sequence_active_status;
	endproperty
	a_start: assert property (p_start) else $error("sequence did not start");
	property p_stop; !$past(ctl_q[CT_ENABLE], 2) && !$past(ctl_q[CT_ENABLE], 3) |-> !sequence_active_status; endproperty
	a_stop: assert property (p_stop) else $error("sequence active without enable");
endmodule // pwmcs_channel_props

bind pwmcs_channel pwmcs_channel_props #(.MODULE_CYCLE_CYC(MODULE_CYCLE_CYC), .PERIOD_CFG_US(PERIOD_CFG_US)) u_props (
	.clk_sys(clk_sys),
	.rst(rst),
	.axi_req(axi_req),
	.axi_rsp(axi_rsp),
	.pulse_output_a(pulse_output_a),
	.sequence_active_status(sequence_active_status)
);

// >>> tb/pwmcs_host.sv
// control program model: axi4-lite master that reaches the channel registers
`timescale 1ns/1ps
module pwmcs_host
	import pwmcs_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// register bus
	output pwmcs_pkg::pwmcs_axi_req_t axi_req,
	input wire pwmcs_pkg::pwmcs_axi_rsp_t axi_rsp
);
	initial axi_req = '0;
	//==============================================================
	// bus cycles; bready and rready go up with the request and drop once the answer is sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk_sys);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge clk_sys);
			if (aw && axi_rsp.awready)
			begin
				aw = 1'b0;
				axi_req.awvalid <= 1'b0;
				axi_req.awaddr <= ~a;
			end
			if (w && axi_rsp.wready)
			begin
				w = 1'b0;
				axi_req.wvalid <= 1'b0;
				axi_req.wdata <= ~d;
			end
		end
		while (!axi_rsp.bvalid) @(posedge clk_sys);
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		axi_req.rready <= 1'b1;
		do @(posedge clk_sys); while (!axi_rsp.arready);
		axi_req.arvalid <= 1'b0;
		axi_req.araddr <= ~a;
		while (!axi_rsp.rvalid) @(posedge clk_sys);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
endmodule // pwmcs_host

// >>> tb/pwmcs_channel_test.sv
// self-checking test of the pwm channel control slot
`timescale 1ns/1ps
module pwmcs_channel_test;
	import pwmcs_pkg::*;
	localparam int MC = 20;
	localparam logic [31:0] RUN = 32'h0002_0000;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	pwmcs_axi_req_t axi_req;
	pwmcs_axi_rsp_t axi_rsp;
	logic pulse_output_a;
	logic sequence_active_status;
	int n_fail = 0;
	int n_compared = 0;
	logic [31:0] fv [3] = '{32'h0, 32'h0001_86A1, 32'h0001_86A0};
	logic [31:0] fe [3] = '{32'h1, 32'h1, 32'h0};
	logic [31:0] cv [5] = '{32'h7D0, 32'h63, 32'h64, 32'h0098_9681, 32'h0098_9680};
	logic [31:0] ce [5] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
	logic [31:0] cp [5] = '{32'h7D0, 32'h7D0, 32'h64, 32'h64, 32'h0098_9680};
	always #25 clk_sys = ~clk_sys;
	pwmcs_channel #(.MODULE_CYCLE_CYC(MC), .PERIOD_CFG_US(32'h3E8)) uut (
		.clk_sys(clk_sys),
		.rst(rst),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp),
		.pulse_output_a(pulse_output_a),
		.sequence_active_status(sequence_active_status)
	);
	pwmcs_host host (
		.clk_sys(clk_sys),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp)
	);
	//==============================================================
	// helpers
	function automatic logic [31:0] b(input int n);
		return 32'h1 << n;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// read-only and unmapped places refuse writes
	task automatic w32(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		host.wr(a, d, r);
		chk({30'h0, r}, {30'h0, (a >= ADR_FEEDBACK) ? RESP_SLVERR : RESP_OKAY});
	endtask
	task automatic ex(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		chk({30'h0, r}, {30'h0, (a > ADR_PERIOD) ? RESP_SLVERR : RESP_OKAY});
		chk(d & m, e);
	endtask
	task automatic tk;
		repeat (MC + 4) @(posedge clk_sys);
	endtask
	task automatic pin(input logic [1:0] e);
		// the first pwm step lands one microsecond after the start
		repeat (CLK_PER_US + 4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({30'h0, sequence_active_status, pulse_output_a}, {30'h0, e});
	endtask
	task automatic wrap_up;
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	//==============================================================
	// scenarios
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		ex(ADR_PERIOD, ALL, 32'h3E8);
		ex(ADR_RECORD, ALL, 32'h3E8);
		ex(ADR_FEEDBACK, ALL, 32'h0);
		ex(8'h1C, ALL, 32'h0);
		w32(ADR_FEEDBACK, ALL);
		w32(ADR_CONTROL, RUN);
		w32(ADR_CONTROL, RUN | 32'h0001_0003);
		foreach (fv[i])
		begin
			w32(ADR_SETPOINT, fv[i]);
			tk;
			ex(ADR_FEEDBACK, b(FB_SET_ERR), fe[i] << FB_SET_ERR);
			if (i < 2)
				pin(2'b10);
		end
		w32(ADR_CONTROL, RUN | 32'h2);
		w32(ADR_SLOT_VALUE, 32'h1F4);
		w32(ADR_SLOT_CTRL, 32'h1);
		tk;
		ex(ADR_PERIOD, ALL, 32'h1F4);
		ex(ADR_RECORD, ALL, 32'h1F4);
		ex(ADR_FEEDBACK, b(FB_ACK), b(FB_ACK));
		w32(ADR_SLOT_VALUE, 32'h2BC);
		tk;
		ex(ADR_PERIOD, ALL, 32'h1F4);
		w32(ADR_SLOT_CTRL, 32'h0);
		tk;
		ex(ADR_FEEDBACK, b(FB_ACK), 32'h0);
		ex(ADR_PERIOD, ALL, 32'h1F4);
		w32(ADR_SLOT_CTRL, 32'h2);
		tk;
		ex(ADR_FEEDBACK, b(FB_LD_ERR) | b(FB_ACK), b(FB_LD_ERR));
		w32(ADR_SLOT_VALUE, 32'h320);
		w32(ADR_SLOT_CTRL, 32'h1);
		tk;
		ex(ADR_PERIOD, ALL, 32'h1F4);
		w32(ADR_CONTROL, RUN | 32'h202);
		tk;
		w32(ADR_CONTROL, RUN | 32'h2);
		tk;
		ex(ADR_FEEDBACK, b(FB_LD_ERR) | b(FB_ACK), b(FB_ACK));
		ex(ADR_PERIOD, ALL, 32'h320);
		w32(ADR_SLOT_CTRL, 32'h11);
		foreach (cv[i])
		begin
			w32(ADR_SLOT_VALUE, cv[i]);
			tk;
			ex(ADR_FEEDBACK, b(FB_VAL_ERR) | b(FB_ACK), (ce[i] << FB_VAL_ERR) | b(FB_ACK));
			ex(ADR_PERIOD, ALL, cp[i]);
		end
		w32(ADR_CONTROL, RUN | 32'h0004_0002);
		w32(ADR_SLOT_VALUE, 32'hA);
		tk;
		ex(ADR_PERIOD, ALL, 32'hA);
		ex(ADR_RECORD, ALL, 32'h320);
		w32(ADR_SLOT_VALUE, 32'h5);
		w32(ADR_SLOT_CTRL, 32'h0);
		tk;
		ex(ADR_PERIOD, ALL, 32'hA);
		w32(ADR_CONTROL, 32'h2);
		w32(ADR_CONTROL, RUN | 32'h2);
		ex(ADR_FEEDBACK, b(FB_VAL_ERR) | b(FB_SET_ERR) | b(FB_LD_ERR) | b(FB_ACK), 32'h0);
		ex(ADR_PERIOD, ALL, 32'h3E8);
		ex(ADR_RECORD, ALL, 32'h3E8);
		w32(ADR_CONTROL, RUN | 32'h8);
		pin(2'b01);
		w32(ADR_SETPOINT, 32'h7FFF);
		w32(ADR_CONTROL, RUN | 32'h3);
		pin(2'b11);
		ex(ADR_FEEDBACK, b(FB_SW_EN) | b(FB_ACTIVE) | b(FB_DQA), b(FB_SW_EN) | b(FB_ACTIVE) | b(FB_DQA));
		w32(ADR_CONTROL, RUN | 32'h1);
		pin(2'b10);
		w32(ADR_CONTROL, RUN | 32'h3);
		pin(2'b11);
		w32(ADR_SETPOINT, 32'h8000);
		repeat (20100) @(posedge clk_sys);
		pin(2'b10);
		w32(ADR_CONTROL, RUN | 32'h2);
		pin(2'b00);
		wrap_up();
	end
	// the scenarios need about 21000 cycles
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		wrap_up();
	end
endmodule // pwmcs_channel_test
